/* core/spi_flash_erase_sequencer.sv */
// Erase sequencer of a small serial flash: SPI command capture, sector and
// chip erase timing, write-enable latch and status readout.
// Assumes an SPI host in mode 0/3 that keeps the serial clock still while
// chip select is high, and a memory array that erases what busy/sectors show.
//
// How it works
// - Address bits 16:15 select one of four sectors
// - Sector erase only for unlocked existing sector
// - Sector erase timed internally, no host action
// - During sector erase only status read works
// - Write enable cleared when sector erase ends
// - Chip erase covers all unlocked sectors only
// - Chip erase timed internally, about 3.5 s
// - During chip erase only status read works
// - Write enable cleared when chip erase ends
// - Status bit 0 high while a cycle runs
// - Modifying command without write enable is ignored
`timescale 1ns/1ps
module spi_flash_erase_sequencer
   import spi_erase_pkg::*;
#(
   parameter logic [31:0] CHIP_CYCLES = spi_erase_pkg::CHIP_ERASE_CYCLES,
   parameter logic [31:0] SECTOR_CYCLES = spi_erase_pkg::SECTOR_ERASE_CYCLES
) (
   // System clock and reset
   input wire logic clk,
   input wire logic reset,
   // SPI link
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   output logic so,
   output logic soOe,
   // Configuration pins
   input wire logic [1:0] bpLevel,
   input wire logic partLarge,
   // Memory array side
   output logic [3:0] eraseSectors,
   output logic [7:0] eraseByte,
   output logic eraseDone,
   // Status
   output logic busy,
   output logic writeEnabled
);
   import spi_erase_pkg::*;

   // Link domain: output side cleared by chip select, input side restarted by the frame's first clock
   logic [31:0] shift_r;
   logic [31:0] shift_nxt;
   logic [5:0] bitCnt_r;
   logic [5:0] bitCnt_nxt;
   logic fresh_r;
   logic so_r;
   logic so_nxt;
   logic soOe_r;
   logic soOe_nxt;
   logic [6:0] txSh_r;
   logic [6:0] txSh_nxt;
   logic [2:0] txCnt_r;
   logic [2:0] txCnt_nxt;
   status_s statLink;

   // System domain
   erase_state_e state_r;
   erase_state_e state_nxt;
   logic [31:0] timer_r;
   logic [31:0] timer_nxt;
   logic wel_r;
   logic wel_nxt;
   logic busy_r;
   logic busy_nxt;
   logic [3:0] sectors_r;
   logic [3:0] sectors_nxt;
   logic done_r;
   logic done_nxt;
   logic [7:0] eraseByte_r;
   logic selPrev_r;
   logic selPrev_nxt;
   logic [3:0] pinSync;
   logic csSel;
   logic [1:0] bpSync;
   logic largeSync;
   status_s statSys;
   frame_s frame;
   logic frameEnd;
   logic [3:0] existMask;
   logic [3:0] lockMask;
   logic [3:0] sectorHit;
   logic [3:0] sectorMask;
   logic [3:0] chipMask;

   // Link input shifting on the rising serial clock edge. The first edge of
   // a frame restarts the count, so the last frame stays readable after the
   // deselect until the next frame begins.
   always_comb begin
      if (fresh_r) begin
         shift_nxt = {31'h0, si};
         bitCnt_nxt = 6'h01;
      end else begin
         shift_nxt = {shift_r[30:0], si};
         bitCnt_nxt = (bitCnt_r == BITS_MAX) ? bitCnt_r : bitCnt_r + 6'h01;
      end
   end

   // Armed by the deselect itself, since the serial clock is still then
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   always_ff @(posedge sck) begin
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
   end

   // Status reaches the link clock through its own synchroniser;
   // the host's 8 opcode clocks flush it before the first bit goes out.
   sync_two_ff #(
      .WIDTH(4)
   ) u_stat_sync (
      .clk(sck),
      .reset(csN),
      .din(statSys),
      .dout(statLink)
   );

   // Status byte repeats every 8 clocks while the frame lasts
   always_comb begin
      so_nxt = so_r;
      soOe_nxt = soOe_r;
      txSh_nxt = txSh_r;
      txCnt_nxt = txCnt_r;
      if (!soOe_r) begin
         if (bitCnt_r == BITS_OPCODE && shift_r[7:0] == OP_STATUS_READ) begin
            soOe_nxt = 1'b1;
            so_nxt = 1'b0;
            txSh_nxt = {3'h0, statLink};
            txCnt_nxt = 3'h1;
         end
      end else if (txCnt_r == 3'h0) begin
         so_nxt = 1'b0;
         txSh_nxt = {3'h0, statLink};
         txCnt_nxt = 3'h1;
      end else begin
         so_nxt = txSh_r[6];
         txSh_nxt = {txSh_r[5:0], 1'b0};
         txCnt_nxt = txCnt_r + 3'h1;
      end
   end

   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         so_r <= 1'b0;
         soOe_r <= 1'b0;
         txSh_r <= 7'h00;
         txCnt_r <= 3'h0;
      end else begin
         so_r <= so_nxt;
         soOe_r <= soOe_nxt;
         txSh_r <= txSh_nxt;
         txCnt_r <= txCnt_nxt;
      end
   end

   // Pins into the system domain
   sync_two_ff #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk(clk),
      .reset(reset),
      .din({~csN, partLarge, bpLevel}),
      .dout(pinSync)
   );

   assign csSel = pinSync[3];
   assign largeSync = pinSync[2];
   assign bpSync = pinSync[1:0];
   assign frameEnd = selPrev_r & ~csSel;

   // Frame registers are quiet once chip select is high, so the system
   // domain reads them only after the synchronised deselect.
   always_comb begin
      frame.bits = bitCnt_r;
      frame.addr = shift_r[23:0];
      frame.opcode = (bitCnt_r == BITS_ADDR_CMD) ? shift_r[31:24] : shift_r[7:0];
   end

   // Sector decode and protection
   always_comb begin
      existMask = largeSync ? SECTORS_LARGE : SECTORS_SMALL;
      lockMask = LOCK_NONE;
      if (largeSync) begin
         case (bpSync)
            BP_NONE: lockMask = LOCK_NONE;
            BP_QUARTER: lockMask = LOCK_QUARTER;
            BP_HALF: lockMask = LOCK_HALF;
            BP_ALL: lockMask = LOCK_ALL;
            default: lockMask = LOCK_ALL;
         endcase
      end else if (bpSync == BP_ALL) begin
         lockMask = LOCK_ALL;
      end
      sectorHit = 4'b0001 << frame.addr[SECTOR_MSB:SECTOR_LSB];
      sectorMask = sectorHit & existMask & ~lockMask;
      chipMask = existMask & ~lockMask;
   end

   // Erase sequencing
   always_comb begin
      state_nxt = state_r;
      timer_nxt = timer_r;
      wel_nxt = wel_r;
      sectors_nxt = sectors_r;
      done_nxt = 1'b0;
      selPrev_nxt = csSel;
      case (state_r)
         ST_IDLE: begin
            if (frameEnd) begin
               if (frame.bits == BITS_OPCODE && frame.opcode == OP_WRITE_ENABLE) begin
                  wel_nxt = 1'b1;
               end else if (frame.bits == BITS_OPCODE &&
                            frame.opcode == OP_WRITE_DISABLE) begin
                  wel_nxt = 1'b0;
               end else if (wel_r && frame.bits == BITS_OPCODE &&
                            frame.opcode == OP_CHIP_ERASE && chipMask != 4'h0) begin
                  state_nxt = ST_CHIP;
                  sectors_nxt = chipMask;
                  timer_nxt = CHIP_CYCLES - 32'h1;
               end else if (wel_r && frame.bits == BITS_ADDR_CMD &&
                            frame.opcode == OP_SECTOR_ERASE && sectorMask != 4'h0) begin
                  state_nxt = ST_SECTOR;
                  sectors_nxt = sectorMask;
                  timer_nxt = SECTOR_CYCLES - 32'h1;
               end
            end
         end
         ST_SECTOR, ST_CHIP: begin
            // Frames arriving now are dropped; status read is served on the link
            if (timer_r == 32'h0) begin
               state_nxt = ST_IDLE;
               wel_nxt = 1'b0;
               sectors_nxt = 4'h0;
               done_nxt = 1'b1;
            end else begin
               timer_nxt = timer_r - 32'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            sectors_nxt = 4'h0;
            timer_nxt = 32'h0;
         end
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         timer_r <= 32'h0;
         wel_r <= 1'b0;
         busy_r <= 1'b0;
         sectors_r <= 4'h0;
         done_r <= 1'b0;
         selPrev_r <= 1'b0;
         eraseByte_r <= ERASED_BYTE;
      end else begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         wel_r <= wel_nxt;
         busy_r <= busy_nxt;
         sectors_r <= sectors_nxt;
         done_r <= done_nxt;
         selPrev_r <= selPrev_nxt;
         eraseByte_r <= ERASED_BYTE;
      end
   end

   always_comb begin
      statSys.bp = bpSync;
      statSys.wel = wel_r;
      statSys.busy = busy_r;
   end

   assign so = so_r;
   assign soOe = soOe_r;
   assign eraseSectors = sectors_r;
   assign eraseByte = eraseByte_r;
   assign eraseDone = done_r;
   assign busy = busy_r;
   assign writeEnabled = wel_r;

endmodule

/* core/spi_erase_pkg.sv */
// Constants, opcodes and carrier types of the serial flash erase sequencer.
// Assumes a 200 MHz system clock and an SPI mode 0/3 host on the link.
package spi_erase_pkg;

   // System clock and erase cycle times
   localparam int CLK_PERIOD_NS = 5;
   localparam real NS_PER_S = 1.0e9;
   localparam real CHIP_ERASE_S = 3.5;
   localparam real SECTOR_ERASE_S = 1.0;
   localparam logic [31:0] CHIP_ERASE_CYCLES =
      32'(longint'(CHIP_ERASE_S * NS_PER_S) / CLK_PERIOD_NS);
   localparam logic [31:0] SECTOR_ERASE_CYCLES =
      32'(longint'(SECTOR_ERASE_S * NS_PER_S) / CLK_PERIOD_NS);

   // Command opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h52;
   localparam logic [7:0] OP_CHIP_ERASE = 8'h62;

   // Frame lengths in bits
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
   localparam logic [5:0] BITS_MAX = 6'h3f;

   // Address and sector layout
   localparam int SECTOR_LSB = 15;
   localparam int SECTOR_MSB = 16;
   localparam logic [3:0] SECTORS_LARGE = 4'hf;
   localparam logic [3:0] SECTORS_SMALL = 4'h3;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // Block protection levels and locked-sector masks
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [1:0] BP_ALL = 2'h3;
   localparam logic [3:0] LOCK_NONE = 4'h0;
   localparam logic [3:0] LOCK_QUARTER = 4'h8;
   localparam logic [3:0] LOCK_HALF = 4'hc;
   localparam logic [3:0] LOCK_ALL = 4'hf;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SECTOR = 2'b01,
      ST_CHIP = 2'b10
   } erase_state_e;

   // Status as seen by the status-read command, low bits of the byte
   typedef struct packed {
      logic [1:0] bp;
      logic wel;
      logic busy;
   } status_s;

   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [5:0] bits;
   } frame_s;

endpackage

/* core/sync_two_ff.sv */
// Two flip-flop synchroniser, one stage pair per bit.
// Assumes each bit is an independent slow level; no word coherence.
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Level in and out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge clk) begin
            if (reset) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= din[i];
               hold_r <= meta_r;
            end
         end
         assign dout[i] = hold_r;
      end
   endgenerate
endmodule

/* tb/spi_flash_erase_sequencer_properties.sv */
// Port checker of the erase sequencer.
// Assumes bpLevel and partLarge are only changed while no erase runs.
`timescale 1ns/1ps
module spi_flash_erase_sequencer_properties
   import spi_erase_pkg::*;
#(
   parameter logic [31:0] CHIP_CYCLES = 32'h7d0,
   parameter logic [31:0] SECTOR_CYCLES = 32'h4b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Watched ports
   input wire logic [1:0] bpLevel,
   input wire logic partLarge,
   input wire logic [3:0] eraseSectors,
   input wire logic [7:0] eraseByte,
   input wire logic eraseDone,
   input wire logic busy,
   input wire logic writeEnabled
);
   logic [31:0] busyLen_r;
   logic [31:0] busyLen_nxt;
   logic [3:0] lockMask;
   always_comb begin
      busyLen_nxt = (busy && !reset) ? busyLen_r + 32'h1 : 32'h0;
      lockMask = (bpLevel == BP_ALL) ? LOCK_ALL : (bpLevel == BP_HALF) ? LOCK_HALF :
         (bpLevel == BP_QUARTER) ? LOCK_QUARTER : LOCK_NONE;
   end
   always_ff @(posedge clk) begin
      busyLen_r <= busyLen_nxt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   byte_ones_a: assert property (eraseByte == ERASED_BYTE)
      else $error("erased byte value wrong");
   mask_busy_a: assert property (busy == (eraseSectors != 4'h0))
      else $error("sector mask and busy disagree");
   lock_skip_a: assert property (busy |-> (eraseSectors & lockMask) == 4'h0)
      else $error("locked sector erased");
   small_part_a: assert property (!partLarge |-> eraseSectors[3:2] == 2'h0)
      else $error("missing sector erased");
   start_wel_a: assert property ($rose(busy) |-> $past(writeEnabled))
      else $error("erase started without write enable");
   done_pulse_a: assert property (eraseDone |=> !eraseDone)
      else $error("done longer than one cycle");
   end_clear_a: assert property ($fell(busy) |-> eraseDone && !writeEnabled)
      else $error("cycle end without done or latch clear");
   cycle_hold_a: assert property (busy && $past(busy) |-> $stable(eraseSectors)
      && $stable(writeEnabled)) else $error("state changed during erase");
   busy_len_a: assert property ($fell(busy) |-> busyLen_r == SECTOR_CYCLES
      || busyLen_r == CHIP_CYCLES) else $error("erase cycle length wrong");
endmodule

/* tb/spi_host_model.sv */
// SPI host model, mode 0, MSB first; sck stands still between frames.
// Assumes one frame at a time; si toggles whenever it carries nothing.
`timescale 1ns/1ps
module spi_host_model #(
   parameter real HALF = 62.5
) (
   // Link
   output logic sck,
   output logic csN,
   output logic si,
   input wire logic so
);
   // A deselect edge at start arms the link side before the first frame
   initial begin
      sck = 1'b0;
      csN = 1'b0;
      si = 1'b0;
      #1 csN = 1'b1;
   end
   // Sends n bits of d, then samples nRx bits of so into rx
   task automatic frame(input logic [31:0] d, input int n, input int nRx, output logic [7:0] rx);
      rx = 8'h00;
      csN = 1'b0;
      for (int i = n - 1; i >= -nRx; i--) begin
         si = (i >= 0) ? d[i] : ~si;
         #(HALF) sck = 1'b1;
         if (i < 0) rx = {rx[6:0], so};
         #(HALF) sck = 1'b0;
      end
      #(HALF) csN = 1'b1;
      si = ~si;
      #(4 * HALF);
   endtask
endmodule

/* tb/spi_flash_erase_sequencer_bench.sv */
// Bench of the erase sequencer: host model on the link, straps driven here.
// Assumes shortened erase counts; every expectation follows from them.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin errorCnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module spi_flash_erase_sequencer_bench
   import spi_erase_pkg::*;
;
   localparam logic [31:0] CHIPC = 32'h7d0;
   localparam logic [31:0] SECC = 32'h4b0;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sck, csN, si, so, soOe, partLarge, eraseDone, busy, writeEnabled;
   logic [1:0] bpLevel;
   logic [3:0] eraseSectors;
   logic [7:0] eraseByte, rx;
   int errorCnt = 0;
   int checksDone = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   spi_flash_erase_sequencer #(.CHIP_CYCLES(CHIPC), .SECTOR_CYCLES(SECC)) uut (.clk, .reset,
      .sck, .csN, .si, .so, .soOe, .bpLevel, .partLarge, .eraseSectors, .eraseByte,
      .eraseDone, .busy, .writeEnabled);
   spi_host_model host (.sck, .csN, .si, .so);
   task automatic give_verdict();
      $display("checks %0d errors %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         errorCnt++;
         give_verdict();
      end
   end
   task automatic send(input logic [31:0] d, input int n);
      host.frame(d, n, 0, rx);
      repeat (8) @(negedge clk);
   endtask
   task automatic status(input logic wl, input logic ex);
      logic [7:0] expByte;
      expByte = {4'h0, bpLevel, wl, ex};
      host.frame({24'h0, OP_STATUS_READ}, 8, 8, rx);
      repeat (8) @(negedge clk);
      `CHK("status byte", expByte, rx)
      `CHK("so released", 1'b0, soOe)
   endtask
   // Write enable, erase frame, then a write disable that a running erase drops, and polls until done
   task automatic erase(input logic [31:0] d, input int n, input logic [3:0] mask);
      send({24'h0, OP_WRITE_ENABLE}, 8);
      send(d, n);
      `CHK("sectors", mask, eraseSectors)
      `CHK("busy", mask != 4'h0, busy)
      send({24'h0, OP_WRITE_DISABLE}, 8);
      `CHK("wel kept", mask != 4'h0, writeEnabled)
      if (mask != 4'h0) status(1'b1, 1'b1);
      for (int i = 0; i < 3000 && busy === 1'b1; i++) @(negedge clk);
      `CHK("busy end", 1'b0, busy)
      `CHK("wel clear", 1'b0, writeEnabled)
      status(1'b0, 1'b0);
   endtask
   task automatic each_sector();
      for (int s = 0; s < 4; s++) erase({OP_SECTOR_ERASE, 7'h7f, 2'(s), 15'h1234}, 32,
         4'h1 << s);
   endtask
   task automatic refused();
      send({OP_SECTOR_ERASE, 24'h0}, 32);
      `CHK("no wel", 1'b0, busy)
      erase({16'h0, OP_SECTOR_ERASE, 8'h0}, 16, 4'h0);
   endtask
   task automatic locked();
      logic [3:0] ex [4] = '{4'hf, 4'h7, 4'h3, 4'h0};
      for (int b = 0; b < 4; b++) begin
         bpLevel = 2'(b);
         erase({24'h0, OP_CHIP_ERASE}, 8, ex[b]);
      end
      bpLevel = BP_QUARTER;
      erase({OP_SECTOR_ERASE, 24'h018000}, 32, 4'h0);
   endtask
   task automatic small_part();
      partLarge = 1'b0;
      bpLevel = BP_NONE;
      erase({OP_SECTOR_ERASE, 24'h00c000}, 32, 4'h2);
      erase({OP_SECTOR_ERASE, 24'h010000}, 32, 4'h0);
      erase({24'h0, OP_CHIP_ERASE}, 8, 4'h3);
      bpLevel = BP_ALL;
      erase({24'h0, OP_CHIP_ERASE}, 8, 4'h0);
   endtask
   initial begin
      bpLevel = BP_NONE;
      partLarge = 1'b1;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("byte", ERASED_BYTE, eraseByte)
      each_sector();
      refused();
      locked();
      small_part();
      give_verdict();
   end
endmodule
bind spi_flash_erase_sequencer spi_flash_erase_sequencer_properties #(.CHIP_CYCLES(CHIP_CYCLES),
   .SECTOR_CYCLES(SECTOR_CYCLES)) props (.clk, .reset, .bpLevel, .partLarge, .eraseSectors,
   .eraseByte, .eraseDone, .busy, .writeEnabled);
